// [pkg/dubp_pkg.sv]
// constants shared by the dual uart host bus port and its channel sets
// assumes one 40 MHz clock and inputs already synchronous to it
package dubp_pkg;

    // ------------------------------------------------------------
    // bus widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;                // host data bus width
    localparam int ADDR_W = 3;                // register address lines
    localparam int NUM_REGS = 8;              // registers per channel

    // ------------------------------------------------------------
    // register offsets within one channel
    // ------------------------------------------------------------
    localparam logic [2:0] REG_DIV_LOW  = 3'h0; // divisor low, latch on
    localparam logic [2:0] REG_DIV_HIGH = 3'h1; // divisor_high_byte, latch on
    localparam logic [2:0] REG_LINE_CTL = 3'h3; // line control
    localparam logic [2:0] REG_MODEM_CTL = 3'h4; // modem control

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LINE_DLAB_BIT = 7;         // divisor latch access
    localparam int MODEM_DTR_BIT = 0;         // dtr output control
    localparam int MODEM_RTS_BIT = 1;         // rts output control

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DIV_LOW_RST  = 8'h01;
    localparam logic [7:0] DIV_HIGH_RST = 8'h00;
    localparam logic [7:0] REG_RST      = 8'h00;
    localparam logic [7:0] DIV_ZERO     = 8'h00;

    // ------------------------------------------------------------
    // identity codes, values arbitrary
    // ------------------------------------------------------------
    localparam logic [7:0] DEV_ID_DFLT  = 8'h5C; // arbitrary value
    localparam logic [7:0] DEV_REV_DFLT = 8'h03; // arbitrary value

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;        // 40 MHz
    localparam int RST_MIN_NS    = 40;        // least reset pulse
    localparam int RST_MIN_CYC   =
        (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] RST_MIN_CNT = 2'(RST_MIN_CYC);

endpackage

// [design/dubp_chan_regs.sv]
// one uart channel register set behind the shared host port
// assumes the port hands it a one-cycle write pulse and a clean reset
`timescale 1ns/100ps

module dubp_chan_regs #(
    parameter logic [7:0] DEV_ID  = dubp_pkg::DEV_ID_DFLT,
    parameter logic [7:0] DEV_REV = dubp_pkg::DEV_REV_DFLT
) (
    input  wire logic                        mclk_i,
    input  wire logic                        chan_rst_i,
    input  wire logic                        wr_i,
    input  wire logic [dubp_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [dubp_pkg::DATA_W-1:0] wdata_i,
    output logic      [dubp_pkg::DATA_W-1:0] rdata_o,
    output logic                             dtr_n_o,
    output logic                             rts_n_o
);
    import dubp_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] regs_q [NUM_REGS];   // plain register file
    logic [7:0] regs_d [NUM_REGS];
    logic [7:0] div_lo_q;            // divisor low byte
    logic [7:0] div_lo_d;
    logic [7:0] div_hi_q;            // divisor_high_byte
    logic [7:0] div_hi_d;
    logic       dlab;                // divisor latch window open
    logic       div_zero;            // both divisor bytes zero
    logic       dtr_n_q;             // registered dtr pin, active low
    logic       dtr_n_d;
    logic       rts_n_q;             // registered rts pin, active low
    logic       rts_n_d;

    assign dlab = regs_q[REG_LINE_CTL][LINE_DLAB_BIT];
    assign div_zero = (div_lo_q == DIV_ZERO) && (div_hi_q == DIV_ZERO);

    // ------------------------------------------------------------
    // next state of the register set
    // ------------------------------------------------------------
    // independent copy per channel, nothing shared
    always_comb begin
        regs_d   = regs_q;
        div_lo_d = div_lo_q;
        div_hi_d = div_hi_q;
        if (chan_rst_i) begin
            // defaults on hardware reset
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_d[i] = REG_RST;
            end
            div_lo_d = DIV_LOW_RST;
            div_hi_d = DIV_HIGH_RST;
        end else if (wr_i) begin
            if (dlab && addr_i == REG_DIV_LOW) begin
                div_lo_d = wdata_i;
            end else if (dlab && addr_i == REG_DIV_HIGH) begin
                div_hi_d = wdata_i;
            end else begin
                regs_d[addr_i] = wdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        regs_q   <= regs_d;
        div_lo_q <= div_lo_d;
        div_hi_q <= div_hi_d;
        dtr_n_q  <= dtr_n_d;
        rts_n_q  <= rts_n_d;
    end

    // ------------------------------------------------------------
    // read mux, registered by the port
    // ------------------------------------------------------------
    always_comb begin
        rdata_o = regs_q[addr_i];
        if (dlab && addr_i == REG_DIV_LOW) begin
            // zero divisor exposes the revision
            rdata_o = div_zero ? DEV_REV : div_lo_q;
        end else if (dlab && addr_i == REG_DIV_HIGH) begin
            // zero divisor exposes the identity
            rdata_o = div_zero ? DEV_ID : div_hi_q;
        end
    end

    // ------------------------------------------------------------
    // serial side modem outputs, inactive high after reset
    // ------------------------------------------------------------
    // taken from the next register value so the pins come from flops
    // yet change on the same edge as the modem control byte
    always_comb begin
        dtr_n_d = ~regs_d[REG_MODEM_CTL][MODEM_DTR_BIT];
        rts_n_d = ~regs_d[REG_MODEM_CTL][MODEM_RTS_BIT];
    end

    assign dtr_n_o = dtr_n_q;
    assign rts_n_o = rts_n_q;

endmodule

// [design/dubp_host_port.sv]
// shared 8-bit host bus port of a dual uart, both bus styles
// assumes all pins are sampled on mclk_i; no other clock is needed
`timescale 1ns/100ps

module dubp_host_port #(
    parameter logic [7:0] DEV_ID  = dubp_pkg::DEV_ID_DFLT,
    parameter logic [7:0] DEV_REV = dubp_pkg::DEV_REV_DFLT
) (
    input  wire logic                        mclk_i,
    input  wire logic                        resetn_i,
    input  wire logic                        bus_style_i,
    input  wire logic                        reset_pin_i,
    input  wire logic                        bus_isolate_sleep_i,
    input  wire logic                        chan_a_select_n_i,
    input  wire logic                        chan_b_select_n_i,
    input  wire logic                        read_strobe_n_i,
    input  wire logic                        write_strobe_n_i,
    input  wire logic                        rw_dir_i,
    input  wire logic                        channel_addr_bit_i,
    input  wire logic [dubp_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [dubp_pkg::DATA_W-1:0] data_i,
    output logic      [dubp_pkg::DATA_W-1:0] data_o,
    output logic                             data_oe_n_o,
    output logic                             dtr_a_n_o,
    output logic                             rts_a_n_o,
    output logic                             dtr_b_n_o,
    output logic                             rts_b_n_o
);
    import dubp_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic       pin_rst_act;          // reset pin in its active level
    logic [1:0] rst_cnt_q;            // reset pin qualify counter
    logic [1:0] rst_cnt_d;
    logic       chan_rst;             // reset to both channels
    logic       sel_a;                // channel a addressed
    logic       sel_b;                // channel b addressed
    logic       rd_req;               // read cycle in progress
    logic       wr_req;               // write cycle in progress
    logic       wr_seen_q;            // write seen last cycle
    logic       wr_seen_d;
    logic       wr_pulse;             // first cycle of a write
    logic [7:0] rdata_a;              // channel a read mux
    logic [7:0] rdata_b;              // channel b read mux
    logic [7:0] data_q;               // registered read data
    logic [7:0] data_d;
    logic       oe_n_q;               // registered drive enable
    logic       oe_n_d;

    // ------------------------------------------------------------
    // hardware reset
    // ------------------------------------------------------------
    // pin level meaning flips with the bus style
    assign pin_rst_act = bus_style_i ? reset_pin_i : ~reset_pin_i;

    // short glitches shorter than the least pulse are not taken
    always_comb begin
        rst_cnt_d = 2'h0;
        if (pin_rst_act) begin
            // saturate at the qualify count
            rst_cnt_d = (rst_cnt_q == RST_MIN_CNT) ? rst_cnt_q
                                                   : rst_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rst_cnt_q <= 2'h0;
        end else begin
            rst_cnt_q <= rst_cnt_d;
        end
    end

    // system reset or a qualified pin pulse clears both channels
    assign chan_rst = !resetn_i || (rst_cnt_q == RST_MIN_CNT);

    // ------------------------------------------------------------
    // channel select decode
    // ------------------------------------------------------------
    // the decode alone picks the channel on the shared bus
    always_comb begin
        sel_a  = 1'b0;
        sel_b  = 1'b0;
        rd_req = 1'b0;
        wr_req = 1'b0;
        if (bus_isolate_sleep_i) begin
            // isolated: nothing on the bus is seen
            sel_a = 1'b0;
        end else if (bus_style_i) begin // style pin picks protocol
            // two selects, channel bit not looked at
            sel_a  = ~chan_a_select_n_i;
            sel_b  = ~chan_b_select_n_i;
            // separate active-low strobes
            rd_req = ~read_strobe_n_i && (sel_a || sel_b);
            wr_req = ~write_strobe_n_i && (sel_a || sel_b);
        end else begin
            // one select plus channel bit
            sel_a  = ~chan_a_select_n_i && ~channel_addr_bit_i;
            sel_b  = ~chan_a_select_n_i && channel_addr_bit_i;
            rd_req = ~chan_a_select_n_i && rw_dir_i;
            wr_req = ~chan_a_select_n_i && ~rw_dir_i;
        end
    end

    // ------------------------------------------------------------
    // write strobe edge, one write per bus cycle
    // ------------------------------------------------------------
    // sampled on the bus clock, not the baud oscillator
    always_comb begin
        wr_seen_d = wr_req;
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            wr_seen_q <= 1'b0;
        end else begin
            wr_seen_q <= wr_seen_d;
        end
    end

    // both channels take the pulse when both are selected
    assign wr_pulse = wr_req && !wr_seen_q;

    // ------------------------------------------------------------
    // channel register sets
    // ------------------------------------------------------------
    dubp_chan_regs #(
        .DEV_ID  (DEV_ID),
        .DEV_REV (DEV_REV)
    ) u_chan_a (
        .mclk_i     (mclk_i),
        .chan_rst_i (chan_rst),
        .wr_i       (wr_pulse && sel_a),
        .addr_i     (addr_i),
        .wdata_i    (data_i),
        .rdata_o    (rdata_a),
        .dtr_n_o    (dtr_a_n_o),
        .rts_n_o    (rts_a_n_o)
    );

    dubp_chan_regs #(
        .DEV_ID  (DEV_ID),
        .DEV_REV (DEV_REV)
    ) u_chan_b (
        .mclk_i     (mclk_i),
        .chan_rst_i (chan_rst),
        .wr_i       (wr_pulse && sel_b),
        .addr_i     (addr_i),
        .wdata_i    (data_i),
        .rdata_o    (rdata_b),
        .dtr_n_o    (dtr_b_n_o),
        .rts_n_o    (rts_b_n_o)
    );

    // ------------------------------------------------------------
    // read data and bus drive
    // ------------------------------------------------------------
    // a read of both channels is illegal for the host; channel a
    // wins then so the bus still shows a defined byte
    always_comb begin
        data_d = 8'h00;
        oe_n_d = 1'b1;
        if (rd_req && !chan_rst) begin
            // drive only in a selected read
            oe_n_d = 1'b0;
            data_d = sel_a ? rdata_a : rdata_b;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            data_q <= 8'h00;
            oe_n_q <= 1'b1;
        end else begin
            data_q <= data_d;
            oe_n_q <= oe_n_d;
        end
    end

    // eight data bits, three address lines per channel
    assign data_o      = data_q;
    assign data_oe_n_o = oe_n_q;

endmodule

// [bench/dubp_host_port_asserts.sv]
// concurrent checks on the host pins of the dual uart bus port
// assumes it is bound to dubp_host_port and sees only its ports
`timescale 1ns/100ps

module dubp_host_port_asserts (
    input wire logic       mclk_i,
    input wire logic       resetn_i,
    input wire logic       bus_style_i,
    input wire logic       reset_pin_i,
    input wire logic       bus_isolate_sleep_i,
    input wire logic       chan_a_select_n_i,
    input wire logic       chan_b_select_n_i,
    input wire logic       read_strobe_n_i,
    input wire logic       rw_dir_i,
    input wire logic [7:0] data_o,
    input wire logic       data_oe_n_o,
    input wire logic       dtr_a_n_o,
    input wire logic       rts_a_n_o,
    input wire logic       dtr_b_n_o,
    input wire logic       rts_b_n_o
);
    // ------------------------------------------------------------
    // decoded host intent
    // ------------------------------------------------------------
    logic rd_act;  // a read to some channel this cycle
    logic pin_act; // reset pin at its style-dependent active level
    assign rd_act = bus_style_i ?
        (!read_strobe_n_i && !(chan_a_select_n_i && chan_b_select_n_i)) :
        (!chan_a_select_n_i && rw_dir_i);
    assign pin_act = (reset_pin_i == bus_style_i);

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_idle_no_drive: assert property (
        !rd_act |=> data_oe_n_o) else $error("bus driven without read");
    a_read_drives: assert property (
        rd_act && !bus_isolate_sleep_i && !pin_act && !$past(pin_act)
        |=> !data_oe_n_o)
        else $error("selected read not driven");
    a_sleep_isolates: assert property (
        bus_isolate_sleep_i |=> data_oe_n_o) else $error("drive in sleep");
    a_quiet_bus_zero: assert property (
        data_oe_n_o |-> data_o == 8'h00) else $error("idle data not zero");
    a_pin_clears_modem: assert property (
        pin_act [*4] |-> {dtr_a_n_o, rts_a_n_o, dtr_b_n_o, rts_b_n_o} == 4'hF)
        else $error("modem outputs not reset by pin");
    a_pin_no_drive: assert property (
        pin_act [*4] |-> data_oe_n_o) else $error("drive during pin reset");
    a_strobe_none_sel: assert property (
        bus_style_i && chan_a_select_n_i && chan_b_select_n_i
        |=> data_oe_n_o) else $error("drive with no select");
    a_dir_cs_high: assert property (
        !bus_style_i && chan_a_select_n_i |=> data_oe_n_o)
        else $error("drive with select high");
endmodule

// [bench/dubp_host_model.sv]
// host cpu model: drives either bus style, one-cycle write strobes, two-cycle read strobes
// assumes tasks are called from the bench on the mclk_i domain
`timescale 1ns/100ps

module dubp_host_model (
    input  wire logic       mclk_i,
    input  wire logic       style_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       oe_n_i,
    output logic            sel_a_n_o,
    output logic            sel_b_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic            rw_o,
    output logic            chb_o,
    output logic [2:0]      addr_o,
    output logic [7:0]      wdata_o
);
    initial begin
        {sel_a_n_o, sel_b_n_o, rd_n_o, wr_n_o, rw_o, chb_o} = 6'h3F;
        addr_o = 3'h0;
        wdata_o = 8'h00;
    end

    // ch: 0 = a, 1 = b, 2 = both in strobe style (writes only), a in direction style
    task automatic sel(input logic [1:0] ch, input logic rd);
        if (style_i) begin // two selects, two strobes
            sel_a_n_o <= (ch == 2'h1);
            sel_b_n_o <= (ch == 2'h0);
            rd_n_o <= !rd;
            wr_n_o <= rd;
        end else begin // one select, direction, channel bit
            sel_a_n_o <= 1'b0;
            rw_o <= rd;
        end
        // in strobe style the channel bit lies on purpose
        chb_o <= ch[0] ^ style_i;
    endtask

    // release selects, strobes and direction; one idle edge before the next cycle
    task automatic idle();
        {sel_a_n_o, sel_b_n_o, rd_n_o, wr_n_o, rw_o} <= 5'h1F;
    endtask

    task automatic wr(input logic [1:0] ch, input logic [2:0] a,
                      input logic [7:0] d);
        @(posedge mclk_i);
        sel(ch, 1'b0);
        addr_o <= a;
        wdata_o <= d;
        @(posedge mclk_i);
        idle();
        wdata_o <= ~d; // released data no longer shows the byte
    endtask

    task automatic rd(input logic [1:0] ch, input logic [2:0] a,
                      output logic [7:0] d, output logic oe);
        @(posedge mclk_i);
        sel(ch, 1'b1);
        addr_o <= a;
        @(posedge mclk_i);
        // answer launched at this edge; look once it has settled
        @(negedge mclk_i);
        d = rdata_i;
        oe = oe_n_i;
        @(posedge mclk_i);
        idle();
    endtask
endmodule

// [bench/dubp_host_port_bench.sv]
// self-checking bench for the dual uart host bus port
// assumes the host model and checker are compiled alongside
`timescale 1ns/100ps

module dubp_host_port_bench;
    import dubp_pkg::*;
    logic mclk_i, resetn_i, bus_style_i, reset_pin_i, bus_isolate_sleep_i;
    logic a_sel_n, b_sel_n, rd_n, wr_n, rw, chb, oe_n;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    logic [3:0] modem; // dtr a, rts a, dtr b, rts b
    int fails = 0;
    int checks_done = 0;

    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    dubp_host_model host (.mclk_i(mclk_i), .style_i(bus_style_i),
        .rdata_i(rdata), .oe_n_i(oe_n), .sel_a_n_o(a_sel_n),
        .sel_b_n_o(b_sel_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .rw_o(rw), .chb_o(chb),
        .addr_o(addr), .wdata_o(wdata));

    dubp_host_port uut (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .bus_style_i(bus_style_i), .reset_pin_i(reset_pin_i),
        .bus_isolate_sleep_i(bus_isolate_sleep_i),
        .chan_a_select_n_i(a_sel_n), .chan_b_select_n_i(b_sel_n),
        .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .rw_dir_i(rw),
        .channel_addr_bit_i(chb), .addr_i(addr), .data_i(wdata),
        .data_o(rdata), .data_oe_n_o(oe_n), .dtr_a_n_o(modem[3]),
        .rts_a_n_o(modem[2]), .dtr_b_n_o(modem[1]), .rts_b_n_o(modem[0]));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    // read and expect a driven bus carrying e
    task automatic rdc(input logic [1:0] ch, input logic [2:0] a,
                       input logic [7:0] e);
        logic [7:0] d;
        logic oe;
        host.rd(ch, a, d, oe);
        chk("read data", e, d);
        chk("read enable", 8'h00, {7'h0, oe});
    endtask

    // style changes only under system reset; pin parked inactive
    task automatic set_style(input logic s);
        @(posedge mclk_i);
        resetn_i <= 1'b0;
        bus_style_i <= s;
        reset_pin_i <= !s;
        repeat (16) @(posedge mclk_i);
        resetn_i <= 1'b1;
    endtask

    task automatic pin_pulse(); // active level equals the style pin
        @(posedge mclk_i);
        reset_pin_i <= bus_style_i;
        repeat (4) @(posedge mclk_i);
        reset_pin_i <= !bus_style_i;
        repeat (3) @(posedge mclk_i);
    endtask

    task automatic t_strobe();
        chk("modem after reset", 8'h0F, {4'h0, modem});
        host.wr(2'h2, 3'h7, 8'h3C);
        host.wr(2'h0, 3'h6, 8'hA5);
        host.wr(2'h1, 3'h6, 8'h5A);
        rdc(2'h0, 3'h7, 8'h3C);
        rdc(2'h1, 3'h7, 8'h3C);
        rdc(2'h0, 3'h6, 8'hA5);
        rdc(2'h1, 3'h6, 8'h5A);
        host.wr(2'h0, REG_MODEM_CTL, 8'h03);
        repeat (3) @(posedge mclk_i);
        chk("modem a set", 8'h03, {4'h0, modem});
        $display("test strobe select done");
    endtask

    task automatic t_ident();
        host.wr(2'h1, REG_LINE_CTL, 8'h80);
        host.wr(2'h1, REG_DIV_LOW, DIV_ZERO);
        host.wr(2'h1, REG_DIV_HIGH, DIV_ZERO);
        rdc(2'h1, REG_DIV_HIGH, DEV_ID_DFLT);
        rdc(2'h1, REG_DIV_LOW, DEV_REV_DFLT);
        host.wr(2'h1, REG_DIV_LOW, 8'h05);
        rdc(2'h1, REG_DIV_LOW, 8'h05);
        $display("test identity done");
    endtask

    task automatic t_sleep();
        logic [7:0] d;
        logic oe;
        @(posedge mclk_i);
        bus_isolate_sleep_i <= 1'b1;
        host.wr(2'h0, 3'h7, 8'hFF);
        host.rd(2'h0, 3'h7, d, oe);
        chk("sleep enable", 8'h01, {7'h0, oe});
        chk("sleep data", 8'h00, d);
        @(posedge mclk_i);
        bus_isolate_sleep_i <= 1'b0;
        rdc(2'h0, 3'h7, 8'h3C);
        $display("test sleep done");
    endtask

    task automatic t_pin();
        pin_pulse();
        chk("modem after pin", 8'h0F, {4'h0, modem});
        rdc(2'h0, 3'h7, REG_RST);
        $display("test pin reset done");
    endtask

    task automatic t_dir();
        set_style(1'b0);
        host.wr(2'h0, 3'h5, 8'h11);
        host.wr(2'h1, 3'h5, 8'h22);
        rdc(2'h0, 3'h5, 8'h11);
        rdc(2'h1, 3'h5, 8'h22);
        pin_pulse();
        rdc(2'h1, 3'h5, REG_RST);
        $display("test direction style done");
    endtask

    initial begin
        bus_isolate_sleep_i = 1'b0;
        resetn_i = 1'b0;
        bus_style_i = 1'b1;
        reset_pin_i = 1'b0;
        set_style(1'b1);
        t_strobe();
        t_ident();
        t_sleep();
        t_pin();
        t_dir();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        give_verdict();
    end
endmodule

bind dubp_host_port dubp_host_port_asserts u_chk (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .bus_style_i(bus_style_i),
    .reset_pin_i(reset_pin_i), .bus_isolate_sleep_i(bus_isolate_sleep_i),
    .chan_a_select_n_i(chan_a_select_n_i),
    .chan_b_select_n_i(chan_b_select_n_i),
    .read_strobe_n_i(read_strobe_n_i), .rw_dir_i(rw_dir_i),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .dtr_a_n_o(dtr_a_n_o),
    .rts_a_n_o(rts_a_n_o), .dtr_b_n_o(dtr_b_n_o), .rts_b_n_o(rts_b_n_o));
